// [inc/mpsc_pkg.sv]
package mpsc_pkg;
	localparam int NUM_PUMPS = 6;
	localparam int PCT_W = 7;
	localparam int SPD_W = 16;
	localparam int SEC_W = 10;
	localparam logic [7:0] PCT_FULL = 8'h64;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SPEED = 8'h04;
	localparam logic [7:0] OFS_BANDS = 8'h08;
	localparam logic [7:0] OFS_TRANS = 8'h0C;
	localparam logic [7:0] OFS_DELAY = 8'h10;
	localparam logic [7:0] OFS_SETTLE = 8'h14;
	localparam logic [7:0] OFS_HCLR = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
	localparam logic [7:0] OFS_IRQ_EN = 8'h28;
	localparam logic [7:0] OFS_RUNTIME = 8'h30;
	// Field positions.
	localparam int CTRL_ENA = 0;
	localparam int CTRL_ALT = 1;
	localparam int CTRL_MIDX = 2;
	localparam int BAND_UP = 0;
	localparam int BAND_LO = 8;
	localparam int BAND_ULIM = 16;
	localparam int BAND_LLIM = 24;
	localparam int TRANS_ADD = 0;
	localparam int TRANS_DROP = 8;
	localparam int TRANS_RSV = 16;
	localparam int TRANS_OOS = 24;
	localparam int DLY_HI = 16;
	localparam int IRQ_ADD = 0;
	localparam int IRQ_DROP = 1;
	localparam int IRQ_FAULT = 2;
	localparam int IRQ_W = 3;
	// Values after reset.
	localparam logic [31:0] RST_SPEED = 32'hFFFF_0000;
	localparam logic [6:0] RST_BAND = 7'h0A;
	localparam logic [6:0] RST_LIMIT = 7'h00;
	localparam logic [6:0] RST_TRANS = 7'h3C;
	localparam logic [9:0] RST_SEC = 10'h000;
	// Run-time saturation value and clock rate.
	localparam logic [17:0] HOURS_MAX = 18'h3_FFFF;
	localparam logic [5:0] MINSEC_MAX = 6'h3B;
	localparam int CLK_HZ = 250_000_000;
	localparam int SECOND_CYCLES = CLK_HZ;
	// Per-pump status codes.
	localparam logic [1:0] PST_OFF = 2'h0;
	localparam logic [1:0] PST_DIRECT = 2'h1;
	localparam logic [1:0] PST_MASTER = 2'h2;
	localparam logic [1:0] PST_FAULT = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADD_WAIT, ST_ADD_TRANS, ST_ADD_SETTLE, ST_DROP_WAIT, ST_DROP_TRANS, ST_DROP_SETTLE
	} mpsc_state_e;

	typedef struct packed {
		logic [17:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
	} mpsc_runtime_s;

	typedef struct packed {
		logic [SPD_W-1:0] max_spd;
		logic [SPD_W-1:0] min_spd;
	} mpsc_speed_s;
endpackage : mpsc_pkg

// [rtl/mpsc_staging.sv]
`timescale 1ns/1ps
module mpsc_staging #(
	parameter int TICK_CYCLES = mpsc_pkg::SECOND_CYCLES
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic [15:0] SPEED,
	input wire logic MASTER_ON,
	input wire logic [5:0] PUMP_FAULT,
	output logic [5:0] PUMP_RUN,
	output logic [15:0] SPEED_REF,
	output logic SPEED_FORCE,
	output logic PID_HOLD,
	output logic IRQ
);
	localparam int N = mpsc_pkg::NUM_PUMPS;

	logic ena_r, alt_r;
	logic [2:0] midx_r;
	mpsc_pkg::mpsc_speed_s spd_r;
	logic [6:0] up_band_pct_r, lo_band_pct_r, up_lim_r, lo_lim_r;
	logic [6:0] add_transition_pct_r, drop_transition_pct_r;
	logic [1:0] reserve_pump_count_r;
	logic [5:0] oos_r;
	logic [9:0] start_dly_r, stop_dly_r, settle_start_r, settle_stop_r;
	logic [N-1:0] pump_hours_clear;
	logic [mpsc_pkg::IRQ_W-1:0] irq_stat_r, irq_en_r, irq_evt;
	mpsc_pkg::mpsc_state_e state_r;
	logic [9:0] cnt_r;
	logic [31:0] tick_cnt_r;
	logic tick;
	logic [5:0] fault_d_r;
	mpsc_pkg::mpsc_runtime_s rt [N];
	logic [N-1:0] counting;
	logic wr_hit;

	assign wr_hit = CLK_EN && WR;
	assign tick = CLK_EN && (tick_cnt_r == 32'(TICK_CYCLES - 1));

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			tick_cnt_r <= 32'h0000_0000;
		end else if (CLK_EN) begin
			tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
		end
	end

	// Configuration registers.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ena_r <= 1'b0;
			alt_r <= 1'b0;
			midx_r <= 3'h0;
			spd_r <= mpsc_pkg::RST_SPEED;
			up_band_pct_r <= mpsc_pkg::RST_BAND;
			lo_band_pct_r <= mpsc_pkg::RST_BAND;
			up_lim_r <= mpsc_pkg::RST_LIMIT;
			lo_lim_r <= mpsc_pkg::RST_LIMIT;
			add_transition_pct_r <= mpsc_pkg::RST_TRANS;
			drop_transition_pct_r <= mpsc_pkg::RST_TRANS;
			reserve_pump_count_r <= 2'h0;
			oos_r <= 6'h00;
			start_dly_r <= mpsc_pkg::RST_SEC;
			stop_dly_r <= mpsc_pkg::RST_SEC;
			settle_start_r <= mpsc_pkg::RST_SEC;
			settle_stop_r <= mpsc_pkg::RST_SEC;
			irq_en_r <= 3'h0;
		end else if (wr_hit) begin
			case (ADDR)
				mpsc_pkg::OFS_CTRL: begin
					ena_r <= WDATA[mpsc_pkg::CTRL_ENA];
					alt_r <= WDATA[mpsc_pkg::CTRL_ALT];
					midx_r <= WDATA[mpsc_pkg::CTRL_MIDX +: 3];
				end
				mpsc_pkg::OFS_SPEED: spd_r <= WDATA;
				mpsc_pkg::OFS_BANDS: begin
					up_band_pct_r <= WDATA[mpsc_pkg::BAND_UP +: 7];
					lo_band_pct_r <= WDATA[mpsc_pkg::BAND_LO +: 7];
					// Hard limits are clamped to their band so they can never sit outside it.
					up_lim_r <= (WDATA[mpsc_pkg::BAND_ULIM +: 7] > WDATA[mpsc_pkg::BAND_UP +: 7]) ?
						WDATA[mpsc_pkg::BAND_UP +: 7] : WDATA[mpsc_pkg::BAND_ULIM +: 7];
					lo_lim_r <= (WDATA[mpsc_pkg::BAND_LLIM +: 7] > WDATA[mpsc_pkg::BAND_LO +: 7]) ?
						WDATA[mpsc_pkg::BAND_LO +: 7] : WDATA[mpsc_pkg::BAND_LLIM +: 7];
				end
				mpsc_pkg::OFS_TRANS: begin
					add_transition_pct_r <= WDATA[mpsc_pkg::TRANS_ADD +: 7];
					drop_transition_pct_r <= WDATA[mpsc_pkg::TRANS_DROP +: 7];
					reserve_pump_count_r <= WDATA[mpsc_pkg::TRANS_RSV +: 2];
					oos_r <= WDATA[mpsc_pkg::TRANS_OOS +: 6];
				end
				mpsc_pkg::OFS_DELAY: begin
					start_dly_r <= WDATA[9:0];
					stop_dly_r <= WDATA[mpsc_pkg::DLY_HI +: 10];
				end
				mpsc_pkg::OFS_SETTLE: begin
					settle_start_r <= WDATA[9:0];
					settle_stop_r <= WDATA[mpsc_pkg::DLY_HI +: 10];
				end
				mpsc_pkg::OFS_IRQ_EN: irq_en_r <= WDATA[mpsc_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// A clear selector acts once; it reads back as no.
	assign pump_hours_clear = (wr_hit && ADDR == mpsc_pkg::OFS_HCLR) ? WDATA[N-1:0] : '0;

	// Speed comparisons are done in scaled form to avoid a divider in the trigger path.
	logic [15:0] span, dist_top, dist_bot, add_lvl, drop_lvl;
	logic [23:0] dtop100, dbot100;
	logic in_up, in_lo, hit_up, hit_lo;

	assign span = spd_r.max_spd - spd_r.min_spd;
	assign dist_top = (SPEED >= spd_r.max_spd) ? 16'h0000 : spd_r.max_spd - SPEED;
	assign dist_bot = (SPEED <= spd_r.min_spd) ? 16'h0000 : SPEED - spd_r.min_spd;
	assign dtop100 = 24'(dist_top) * 24'd100;
	assign dbot100 = 24'(dist_bot) * 24'd100;
	assign in_up = dtop100 <= 24'(span) * 24'(up_band_pct_r);
	assign in_lo = dbot100 <= 24'(span) * 24'(lo_band_pct_r);
	assign hit_up = (up_lim_r != 7'h00) && (dtop100 <= 24'(span) * 24'(up_lim_r));
	assign hit_lo = (lo_lim_r != 7'h00) && (dbot100 <= 24'(span) * 24'(lo_lim_r));
	assign add_lvl = spd_r.min_spd + 16'((24'(span) * 24'(add_transition_pct_r)) / 24'd100);
	assign drop_lvl = spd_r.min_spd + 16'((24'(span) * 24'(drop_transition_pct_r)) / 24'd100);

	// Reserves are the highest-numbered pumps; each unavailable pump other than the master releases one.
	logic [N-1:0] unavail, is_master, reserve_blk, add_elig;
	logic [2:0] n_unavail;
	logic [2:0] add_sel, drop_sel;
	logic add_ok, drop_ok;
	logic [29:0] best;

	always_comb begin
		n_unavail = 3'h0;
		for (int i = 0; i < N; i++) begin
			is_master[i] = alt_r && (midx_r == 3'(i));
			unavail[i] = PUMP_FAULT[i] || oos_r[i];
			if (unavail[i] && !is_master[i]) begin
				n_unavail = n_unavail + 3'h1;
			end
		end
		for (int i = 0; i < N; i++) begin
			reserve_blk[i] = (i >= N - int'(reserve_pump_count_r)) &&
				(i - (N - int'(reserve_pump_count_r)) >= int'(n_unavail));
			add_elig[i] = !unavail[i] && !is_master[i] && !PUMP_RUN[i] && !reserve_blk[i];
		end
	end

	always_comb begin
		add_sel = 3'h0;
		add_ok = 1'b0;
		best = '1;
		for (int i = 0; i < N; i++) begin
			if (add_elig[i] && (!add_ok || rt[i] < best)) begin
				add_ok = 1'b1;
				add_sel = 3'(i);
				best = rt[i];
			end
		end
	end

	always_comb begin
		drop_sel = 3'h0;
		drop_ok = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (PUMP_RUN[i] && (!drop_ok || rt[i] > rt[drop_sel])) begin
				drop_ok = 1'b1;
				drop_sel = 3'(i);
			end
		end
	end

	// Staging sequencer: one transition at a time, triggers ignored until settle ends.
	logic add_now, drop_now;
	assign add_now = (state_r == mpsc_pkg::ST_ADD_TRANS) &&
		((add_transition_pct_r == mpsc_pkg::PCT_FULL[6:0]) || SPEED <= add_lvl) && add_ok;
	assign drop_now = (state_r == mpsc_pkg::ST_DROP_TRANS) &&
		((drop_transition_pct_r == 7'h00) || SPEED >= drop_lvl) && drop_ok;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_r <= mpsc_pkg::ST_IDLE;
			cnt_r <= 10'h000;
		end else if (CLK_EN) begin
			if (tick) begin
				cnt_r <= cnt_r + 10'h001;
			end
			case (state_r)
				mpsc_pkg::ST_IDLE: begin
					cnt_r <= 10'h000;
					if (ena_r && add_ok && in_up) begin
						state_r <= hit_up ? mpsc_pkg::ST_ADD_TRANS : mpsc_pkg::ST_ADD_WAIT;
					end else if (ena_r && drop_ok && in_lo) begin
						state_r <= hit_lo ? mpsc_pkg::ST_DROP_TRANS : mpsc_pkg::ST_DROP_WAIT;
					end
				end
				mpsc_pkg::ST_ADD_WAIT: begin
					if (!ena_r || !in_up || !add_ok) begin
						state_r <= mpsc_pkg::ST_IDLE;
					end else if (hit_up || cnt_r >= start_dly_r) begin
						state_r <= mpsc_pkg::ST_ADD_TRANS;
					end
				end
				mpsc_pkg::ST_DROP_WAIT: begin
					if (!ena_r || !in_lo || !drop_ok) begin
						state_r <= mpsc_pkg::ST_IDLE;
					end else if (hit_lo || cnt_r >= stop_dly_r) begin
						state_r <= mpsc_pkg::ST_DROP_TRANS;
					end
				end
				mpsc_pkg::ST_ADD_TRANS: begin
					cnt_r <= 10'h000;
					if (!ena_r || !add_ok) begin
						state_r <= mpsc_pkg::ST_IDLE;
					end else if (add_now) begin
						state_r <= mpsc_pkg::ST_ADD_SETTLE;
					end
				end
				mpsc_pkg::ST_DROP_TRANS: begin
					cnt_r <= 10'h000;
					if (!ena_r || !drop_ok) begin
						state_r <= mpsc_pkg::ST_IDLE;
					end else if (drop_now) begin
						state_r <= mpsc_pkg::ST_DROP_SETTLE;
					end
				end
				mpsc_pkg::ST_ADD_SETTLE: begin
					if (cnt_r >= settle_start_r) begin
						state_r <= mpsc_pkg::ST_IDLE;
					end
				end
				mpsc_pkg::ST_DROP_SETTLE: begin
					if (cnt_r >= settle_stop_r) begin
						state_r <= mpsc_pkg::ST_IDLE;
					end
				end
				default: state_r <= mpsc_pkg::ST_IDLE;
			endcase
		end
	end

	// Contactors; a faulted pump is dropped at once so it cannot keep running blind.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			PUMP_RUN <= 6'h00;
		end else if (CLK_EN) begin
			for (int i = 0; i < N; i++) begin
				if (unavail[i] || is_master[i]) begin
					PUMP_RUN[i] <= 1'b0;
				end else if (add_now && add_sel == 3'(i)) begin
					PUMP_RUN[i] <= 1'b1;
				end else if (drop_now && drop_sel == 3'(i)) begin
					PUMP_RUN[i] <= 1'b0;
				end
			end
		end
	end

	// Master speed override and controller hold.
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			SPEED_REF <= 16'h0000;
			SPEED_FORCE <= 1'b0;
			PID_HOLD <= 1'b0;
		end else if (CLK_EN) begin
			SPEED_FORCE <= 1'b0;
			SPEED_REF <= SPEED;
			if (state_r == mpsc_pkg::ST_ADD_TRANS && add_transition_pct_r != mpsc_pkg::PCT_FULL[6:0]) begin
				SPEED_FORCE <= 1'b1;
				SPEED_REF <= add_lvl;
			end else if (state_r == mpsc_pkg::ST_DROP_TRANS && drop_transition_pct_r != 7'h00) begin
				SPEED_FORCE <= 1'b1;
				SPEED_REF <= drop_lvl;
			end
			PID_HOLD <= (state_r == mpsc_pkg::ST_ADD_SETTLE) || (state_r == mpsc_pkg::ST_DROP_SETTLE);
		end
	end

	// Per-pump run-time counters.
	generate
		for (genvar g = 0; g < N; g++) begin : g_rt
			assign counting[g] = PUMP_RUN[g] || (is_master[g] && MASTER_ON);
			always_ff @(posedge SYS_CLK) begin
				if (!RST_N) begin
					rt[g] <= '0;
				end else if (CLK_EN) begin
					if (pump_hours_clear[g]) begin
						rt[g] <= '0;
					end else if (tick && counting[g] && !(rt[g].hours == mpsc_pkg::HOURS_MAX &&
						rt[g].minutes == mpsc_pkg::MINSEC_MAX && rt[g].seconds == mpsc_pkg::MINSEC_MAX)) begin
						if (rt[g].seconds != mpsc_pkg::MINSEC_MAX) begin
							rt[g].seconds <= rt[g].seconds + 6'h01;
						end else begin
							rt[g].seconds <= 6'h00;
							if (rt[g].minutes != mpsc_pkg::MINSEC_MAX) begin
								rt[g].minutes <= rt[g].minutes + 6'h01;
							end else begin
								rt[g].minutes <= 6'h00;
								rt[g].hours <= rt[g].hours + 18'h0_0001;
							end
						end
					end
				end
			end
		end
	endgenerate

	// Interrupt status: a new event wins over a clear in the same cycle.
	assign irq_evt = {|(PUMP_FAULT & ~fault_d_r), drop_now, add_now};

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			irq_stat_r <= 3'h0;
			fault_d_r <= 6'h00;
			IRQ <= 1'b0;
		end else if (CLK_EN) begin
			fault_d_r <= PUMP_FAULT;
			irq_stat_r <= (irq_stat_r & ~((wr_hit && ADDR == mpsc_pkg::OFS_IRQ_CLR) ?
				WDATA[mpsc_pkg::IRQ_W-1:0] : 3'h0)) | irq_evt;
			IRQ <= |(irq_stat_r & irq_en_r);
		end
	end

	// Pump status word and read port.
	logic [11:0] pst;

	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (PUMP_FAULT[i]) begin
				pst[2*i +: 2] = mpsc_pkg::PST_FAULT;
			end else if (is_master[i]) begin
				pst[2*i +: 2] = mpsc_pkg::PST_MASTER;
			end else if (PUMP_RUN[i]) begin
				pst[2*i +: 2] = mpsc_pkg::PST_DIRECT;
			end else begin
				pst[2*i +: 2] = mpsc_pkg::PST_OFF;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			RDATA <= 32'h0000_0000;
		end else if (CLK_EN) begin
			RDATA <= 32'h0000_0000;
			if (RD) begin
				case (ADDR)
					mpsc_pkg::OFS_CTRL: RDATA <= {27'h0, midx_r, alt_r, ena_r};
					mpsc_pkg::OFS_SPEED: RDATA <= spd_r;
					mpsc_pkg::OFS_BANDS: RDATA <= {1'b0, lo_lim_r, 1'b0, up_lim_r, 1'b0, lo_band_pct_r, 1'b0, up_band_pct_r};
					mpsc_pkg::OFS_TRANS: RDATA <= {2'h0, oos_r, 6'h0, reserve_pump_count_r, 1'b0,
						drop_transition_pct_r, 1'b0, add_transition_pct_r};
					mpsc_pkg::OFS_DELAY: RDATA <= {6'h0, stop_dly_r, 6'h0, start_dly_r};
					mpsc_pkg::OFS_SETTLE: RDATA <= {6'h0, settle_stop_r, 6'h0, settle_start_r};
					mpsc_pkg::OFS_STAT: RDATA <= {13'h0, state_r, 4'h0, pst};
					mpsc_pkg::OFS_IRQ_STAT: RDATA <= {29'h0, irq_stat_r};
					mpsc_pkg::OFS_IRQ_EN: RDATA <= {29'h0, irq_en_r};
					default: begin
						for (int i = 0; i < N; i++) begin
							if (ADDR == mpsc_pkg::OFS_RUNTIME + 8'(4 * i)) begin
								RDATA <= {2'h0, rt[i]};
							end
						end
					end
				endcase
			end
		end
	end
endmodule : mpsc_staging

// [testbench/mpsc_pump_bank.sv]
`timescale 1ns/1ps
module mpsc_pump_bank (
	input wire logic clk,
	input wire logic hold_ref,
	input wire logic [15:0] target,
	input wire logic [15:0] demand,
	input wire logic [5:0] fail_cmd,
	output logic [15:0] speed,
	output logic [5:0] fault
);
	// The master jumps to the forced target; a real ramp would only lengthen the wait.
	assign speed = hold_ref ? target : demand;
	// Fault feedback arrives one cycle after fail_cmd is set, as a real status input would.
	always_ff @(posedge clk) begin
		fault <= fail_cmd;
	end
endmodule : mpsc_pump_bank

// [testbench/mpsc_staging_sva.sv]
`timescale 1ns/1ps
module mpsc_staging_sva #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic [15:0] SPEED,
	input wire logic [5:0] PUMP_FAULT,
	input wire logic [5:0] PUMP_RUN,
	input wire logic [15:0] SPEED_REF,
	input wire logic SPEED_FORCE,
	input wire logic PID_HOLD
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
		else $error("read data not zero outside answer cycle");
	a_add_settle: assert property ((PUMP_RUN & ~$past(PUMP_RUN)) != 6'h00 |=> PID_HOLD)
		else $error("no settle hold after pump start");
	a_hold_cause: assert property ($rose(PID_HOLD) |-> $past(PUMP_RUN) != $past(PUMP_RUN, 2))
		else $error("settle hold without pump switch");
	a_one_pump: assert property ($onehot0(PUMP_RUN & ~$past(PUMP_RUN)))
		else $error("several pumps started at once");
	a_quiet_settle: assert property (PID_HOLD |-> (PUMP_RUN & ~$past(PUMP_RUN)) == 6'h00)
		else $error("pump started during settle");
	a_fault_open: assert property ((PUMP_FAULT & PUMP_RUN) != 6'h00
		|=> (PUMP_FAULT & PUMP_RUN & $past(PUMP_FAULT)) == 6'h00)
		else $error("faulted pump kept running");
	a_speed_pass: assert property (!SPEED_FORCE && $past(RST_N) |-> SPEED_REF == $past(SPEED))
		else $error("speed reference not following master");
	a_force_steady: assert property ($past(SPEED_FORCE) && SPEED_FORCE |-> $stable(SPEED_REF))
		else $error("transition target moved");
endmodule : mpsc_staging_sva

bind mpsc_staging mpsc_staging_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
	.SYS_CLK(SYS_CLK),
	.RST_N(RST_N),
	.RD(RD),
	.RDATA(RDATA),
	.SPEED(SPEED),
	.PUMP_FAULT(PUMP_FAULT),
	.PUMP_RUN(PUMP_RUN),
	.SPEED_REF(SPEED_REF),
	.SPEED_FORCE(SPEED_FORCE),
	.PID_HOLD(PID_HOLD)
);

// [testbench/mpsc_staging_test.sv]
`timescale 1ns/1ps
module mpsc_staging_test;
	logic SYS_CLK;
	logic RST_N;
	logic CLK_EN;
	logic [7:0] ADDR;
	logic [31:0] WDATA;
	logic WR;
	logic RD;
	logic [31:0] RDATA;
	logic [15:0] SPEED;
	logic [15:0] demand;
	logic MASTER_ON;
	logic [5:0] PUMP_FAULT;
	logic [5:0] fail_cmd;
	logic [5:0] PUMP_RUN;
	logic [15:0] SPEED_REF;
	logic SPEED_FORCE;
	logic PID_HOLD;
	logic IRQ;
	logic saw_force;
	logic [31:0] rv;
	logic [31:0] keep;
	int err_total;
	int n_compared;

	mpsc_staging #(.TICK_CYCLES(10)) dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SPEED(SPEED), .MASTER_ON(MASTER_ON),
		.PUMP_FAULT(PUMP_FAULT), .PUMP_RUN(PUMP_RUN), .SPEED_REF(SPEED_REF), .SPEED_FORCE(SPEED_FORCE),
		.PID_HOLD(PID_HOLD), .IRQ(IRQ));
	mpsc_pump_bank bank (.clk(SYS_CLK), .hold_ref(SPEED_FORCE), .target(SPEED_REF), .demand(demand),
		.fail_cmd(fail_cmd), .speed(SPEED), .fault(PUMP_FAULT));

	initial begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		@(negedge SYS_CLK);
		rv = RDATA;
	endtask : rd

	// Drives the master into a speed zone, waits for a pump change inside [lo, hi] cycles, then parks mid-range.
	task stage(input logic [15:0] dem, input logic [5:0] exp, input int lo, input int hi);
		logic [5:0] old;
		int n;
		old = PUMP_RUN;
		saw_force = 1'b0;
		n = 0;
		@(posedge SYS_CLK);
		demand <= dem;
		do begin
			@(negedge SYS_CLK);
			n++;
			if (SPEED_FORCE === 1'b1) begin
				saw_force = 1'b1;
				chk(32'(SPEED_REF), 32'h0000_0258);
			end
		end while (PUMP_RUN === old && n < hi);
		chk(32'(n >= lo), 32'h0000_0001);
		chk(32'(PUMP_RUN), 32'(exp));
		@(posedge SYS_CLK);
		demand <= 16'h01F4;
		repeat (8) @(posedge SYS_CLK);
	endtask : stage

	task t_defaults;
		rd(mpsc_pkg::OFS_BANDS);
		chk(rv, 32'h0000_0A0A);
		rd(mpsc_pkg::OFS_TRANS);
		chk(rv, 32'h0000_3C3C);
		rd(8'h2C);
		chk(rv, 32'h0000_0000);
		rd(mpsc_pkg::OFS_STAT);
		chk(rv, 32'h0000_0000);
		wr(mpsc_pkg::OFS_HCLR, 32'h0000_003F);
		rd(mpsc_pkg::OFS_HCLR);
		chk(rv, 32'h0000_0000);
		$display("defaults done");
	endtask : t_defaults

	task t_direct_add;
		wr(mpsc_pkg::OFS_SPEED, 32'h03E8_0000);
		wr(mpsc_pkg::OFS_TRANS, 32'h0000_3C64);
		wr(mpsc_pkg::OFS_IRQ_EN, 32'h0000_0001);
		wr(mpsc_pkg::OFS_CTRL, 32'h0000_0001);
		stage(16'h03E3, 6'h01, 0, 10);
		chk(32'(saw_force), 32'h0000_0000);
		chk(32'(IRQ), 32'h0000_0001);
		rd(mpsc_pkg::OFS_IRQ_STAT);
		chk(rv & 32'h0000_0001, 32'h0000_0001);
		wr(mpsc_pkg::OFS_IRQ_CLR, 32'h0000_0001);
		repeat (2) @(posedge SYS_CLK);
		chk(32'(IRQ), 32'h0000_0000);
		$display("direct add done");
	endtask : t_direct_add

	task t_start_limits;
		wr(mpsc_pkg::OFS_DELAY, 32'h0005_0005);
		wr(mpsc_pkg::OFS_BANDS, 32'h0005_0A0A);
		stage(16'h03C0, 6'h03, 0, 8);
		wr(mpsc_pkg::OFS_BANDS, 32'h0000_0A0A);
		stage(16'h03C0, 6'h07, 38, 80);
		$display("start limits done");
	endtask : t_start_limits

	task t_transitions;
		wr(mpsc_pkg::OFS_TRANS, 32'h0000_3C3C);
		wr(mpsc_pkg::OFS_DELAY, 32'h0000_0000);
		stage(16'h03E3, 6'h0F, 0, 20);
		chk(32'(saw_force), 32'h0000_0001);
		// The adds above set the enabled add flag again; clear it so the drop is seen on its own.
		wr(mpsc_pkg::OFS_IRQ_CLR, 32'h0000_0007);
		stage(16'h0032, 6'h0E, 0, 20);
		chk(32'(saw_force), 32'h0000_0001);
		chk(32'(IRQ), 32'h0000_0000);
		rd(mpsc_pkg::OFS_IRQ_STAT);
		chk(rv, 32'h0000_0002);
		rd(mpsc_pkg::OFS_RUNTIME);
		keep = rv;
		chk(32'(rv != 32'h0000_0000), 32'h0000_0001);
		repeat (30) @(posedge SYS_CLK);
		rd(mpsc_pkg::OFS_RUNTIME);
		chk(rv, keep);
		rd(mpsc_pkg::OFS_RUNTIME + 8'h14);
		chk(rv, 32'h0000_0000);
		$display("transitions done");
	endtask : t_transitions

	task t_reserve_fault;
		stage(16'h03E3, 6'h1E, 0, 20);
		wr(mpsc_pkg::OFS_TRANS, 32'h0001_3C3C);
		stage(16'h03E3, 6'h1F, 0, 20);
		@(posedge SYS_CLK);
		fail_cmd <= 6'h02;
		repeat (4) @(posedge SYS_CLK);
		chk(32'(PUMP_RUN), 32'h0000_001D);
		rd(mpsc_pkg::OFS_STAT);
		chk(rv & 32'h0007_0FFF, 32'h0000_015D);
		stage(16'h03E3, 6'h3D, 0, 20);
		wr(mpsc_pkg::OFS_HCLR, 32'h0000_0001);
		rd(mpsc_pkg::OFS_RUNTIME);
		chk(32'(rv <= 32'h0000_0001), 32'h0000_0001);
		$display("reserve and fault done");
	endtask : t_reserve_fault

	task t_stop_limit;
		wr(mpsc_pkg::OFS_DELAY, 32'h0005_0000);
		wr(mpsc_pkg::OFS_BANDS, 32'h0500_0A0A);
		wr(mpsc_pkg::OFS_TRANS, 32'h0001_003C);
		stage(16'h001E, 6'h39, 0, 8);
		chk(32'(saw_force), 32'h0000_0000);
		$display("stop limit done");
	endtask : t_stop_limit

	// A drop trigger is held through the settle hold, then alternating master and a frozen clock enable.
	task t_settle;
		int n;
		wr(mpsc_pkg::OFS_SETTLE, 32'h0002_0002);
		stage(16'h001E, 6'h31, 0, 8);
		chk(32'(PID_HOLD), 32'h0000_0001);
		demand <= 16'h001E;
		n = 0;
		while (PID_HOLD === 1'b1 && n < 40) begin
			@(negedge SYS_CLK);
			n++;
		end
		chk(32'(n >= 5 && n <= 14), 32'h0000_0001);
		chk(32'(PUMP_RUN), 32'h0000_0031);
		@(posedge SYS_CLK);
		demand <= 16'h01F4;
		repeat (30) @(posedge SYS_CLK);
		chk(32'(PUMP_RUN), 32'h0000_0021);
		chk(32'(PID_HOLD), 32'h0000_0000);
		wr(mpsc_pkg::OFS_CTRL, 32'h0000_0017);
		wr(mpsc_pkg::OFS_HCLR, 32'h0000_0020);
		repeat (30) @(posedge SYS_CLK);
		chk(32'(PUMP_RUN), 32'h0000_0001);
		rd(mpsc_pkg::OFS_STAT);
		chk(rv & 32'h0007_0FFF, 32'h0000_080D);
		rd(mpsc_pkg::OFS_RUNTIME + 8'h14);
		chk(rv, 32'h0000_0000);
		@(posedge SYS_CLK);
		MASTER_ON <= 1'b1;
		CLK_EN <= 1'b0;
		wr(mpsc_pkg::OFS_CTRL, 32'h0000_0000);
		CLK_EN <= 1'b1;
		repeat (30) @(posedge SYS_CLK);
		rd(mpsc_pkg::OFS_CTRL);
		chk(rv, 32'h0000_0017);
		rd(mpsc_pkg::OFS_RUNTIME + 8'h14);
		chk(32'(rv != 32'h0000_0000), 32'h0000_0001);
		$display("settle and master done");
	endtask : t_settle

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (20000) @(posedge SYS_CLK);
		err_total++;
		report_and_stop;
	end

	initial begin
		RST_N = 1'b0;
		CLK_EN = 1'b1;
		ADDR = 8'h00;
		WDATA = 32'h0000_0000;
		WR = 1'b0;
		RD = 1'b0;
		MASTER_ON = 1'b0;
		demand = 16'h01F4;
		fail_cmd = 6'h00;
		err_total = 0;
		n_compared = 0;
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		t_defaults;
		t_direct_add;
		t_start_limits;
		t_transitions;
		t_reserve_fault;
		t_stop_limit;
		t_settle;
		report_and_stop;
	end
endmodule : mpsc_staging_test
